/* hw/pmrcp_pkg.sv */
// Constants and types for the port 0 clock pin control block.
package pmrcp_pkg;

    typedef enum logic [1:0] {
        PMRCP_MII_MAC = 2'b00,
        PMRCP_MII_PHY = 2'b01,
        PMRCP_RMII_MAC = 2'b10,
        PMRCP_RMII_PHY = 2'b11
    } pmrcp_mode_t;

    localparam logic [3:0] BASIC_CTRL_OFFSET = 4'h0;
    localparam logic [3:0] SPECIAL_CTRL_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;

    localparam int ISOLATE_BIT = 0;
    localparam int CLK_DIR_BIT = 0;
    localparam int CLK_STRENGTH_BIT = 1;
    localparam int TURBO_200_BIT = 2;

    localparam int ST_MODE_LSB = 0;
    localparam int ST_OUTPUT_BIT = 2;
    localparam int ST_PULLDOWN_BIT = 3;
    localparam int ST_INBUF_BIT = 4;
    localparam int ST_DRIVE16_BIT = 5;
    localparam int ST_DRIVER_ON_BIT = 6;
    localparam int ST_CLK_TOGGLE_BIT = 7;

    localparam logic ISOLATE_RESET = 1'b0;
    localparam logic CLK_DIR_RESET = 1'b0;
    localparam logic CLK_STRENGTH_RESET = 1'b0;
    localparam logic TURBO_200_RESET = 1'b0;
    localparam pmrcp_mode_t MODE_RESET = PMRCP_MII_MAC;

    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_DECERR = 2'b11;

endpackage

/* hw/pmrcp_sync2.sv */
// Two flip-flop level synchroniser with synchronous active-low reset.
`timescale 1ns/1ns
module pmrcp_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_q;
    logic meta_d;
    logic q_d;

    always_comb begin
        meta_d = rst_n ? d : 1'b0;
        q_d = rst_n ? meta_q : 1'b0;
    end

    always_ff @(posedge clk) begin
        meta_q <= meta_d;
        q <= q_d;
    end
endmodule

/* hw/pmrcp_strap.sv */
// Synchronises the port 0 mode straps and latches them at reset release.
`timescale 1ns/1ns
module pmrcp_strap (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic strap_bit0,
    input wire logic strap_bit1,
    output pmrcp_pkg::pmrcp_mode_t mode_q
);
    logic bit0_sync;
    logic bit1_sync;
    logic done_q;
    logic done_d;
    pmrcp_pkg::pmrcp_mode_t mode_d;

    pmrcp_sync2 u_sync0 (
        .clk(clk),
        .rst_n(1'b1),
        .d(strap_bit0),
        .q(bit0_sync)
    );

    pmrcp_sync2 u_sync1 (
        .clk(clk),
        .rst_n(1'b1),
        .d(strap_bit1),
        .q(bit1_sync)
    );

    // The straps are taken once, in the first cycle after reset is released.
    always_comb begin
        mode_d = mode_q;
        done_d = done_q;
        if (!rst_n) begin
            mode_d = pmrcp_pkg::MODE_RESET;
            done_d = 1'b0;
        end else if (!done_q) begin
            mode_d = pmrcp_pkg::pmrcp_mode_t'({bit1_sync, bit0_sync});
            done_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        mode_q <= mode_d;
        done_q <= done_d;
    end

    strap_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(rst_n) |=> mode_q == pmrcp_pkg::pmrcp_mode_t'({$past(bit1_sync), $past(bit0_sync)}))
        else $error("mode strap not latched at reset release");

    strap_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        done_q && $past(done_q) |-> $stable(mode_q))
        else $error("latched mode changed without reset");
endmodule

/* hw/pmrcp_top.sv */
// Port 0 transmit-side clock pin control with an AXI4-Lite register slave.
`timescale 1ns/1ns
module pmrcp_top (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic PORT0_TRANSMIT_SIDE_CLOCK_PIN_CLK,
    input wire logic INT_REF_CLK_50M,
    input wire logic PORT0_MODE_STRAP_BIT0,
    input wire logic PORT0_MODE_STRAP_BIT1,
    output logic PORT0_TRANSMIT_SIDE_CLOCK_PIN_O,
    output logic PORT0_TRANSMIT_SIDE_CLOCK_PIN_OE_N,
    output logic PORT0_TRANSMIT_SIDE_CLOCK_PIN_PULLDOWN_EN,
    output logic PORT0_TRANSMIT_SIDE_CLOCK_PIN_INBUF_EN,
    output logic PORT0_TRANSMIT_SIDE_CLOCK_PIN_DRIVE_16MA,
    output logic [1:0] PORT0_MODE,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    pmrcp_pkg::pmrcp_mode_t mode;

    // Register state.
    logic isolate_q, isolate_d;
    logic clk_dir_q, clk_dir_d;
    logic strength_q, strength_d;
    logic turbo_q, turbo_d;

    // Pad control state.
    logic oe_n_q, oe_n_d;
    logic pd_q, pd_d;
    logic inbuf_q, inbuf_d;
    logic drv16_q, drv16_d;

    // Bus state.
    logic aw_have_q, aw_have_d;
    logic w_have_q, w_have_d;
    logic [31:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic wstrb0_q, wstrb0_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    // Link-clock domain state, and the toggle synchronised back to SYS_CLK.
    logic link_rst_n;
    logic link_tog_q, link_tog_d;
    logic tog_sync;

    pmrcp_strap u_strap (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .strap_bit0(PORT0_MODE_STRAP_BIT0),
        .strap_bit1(PORT0_MODE_STRAP_BIT1),
        .mode_q(mode)
    );

    // Returns 1 when the address hits the given register word.
    function automatic logic addr_hit(input logic [31:0] addr, input logic [3:0] offset);
        addr_hit = (addr[31:4] == 28'h0000000) && (addr[3:2] == offset[3:2]);
    endfunction

    // The link-side toggle shows software that a clock really arrives on the pin.
    pmrcp_sync2 u_link_rst (
        .clk(PORT0_TRANSMIT_SIDE_CLOCK_PIN_CLK),
        .rst_n(1'b1),
        .d(RESET_N),
        .q(link_rst_n)
    );

    always_comb begin
        link_tog_d = link_rst_n ? ~link_tog_q : 1'b0;
    end

    always_ff @(posedge PORT0_TRANSMIT_SIDE_CLOCK_PIN_CLK) begin
        link_tog_q <= link_tog_d;
    end

    pmrcp_sync2 u_tog_sync (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .d(link_tog_q),
        .q(tog_sync)
    );

    // AXI4-Lite slave: address and data are taken in either order, one write and one read at a time.
    assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
    assign S_AXI_WREADY = !w_have_q && !bvalid_q;
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RRESP = rresp_q;
    assign S_AXI_RDATA = rdata_q;

    always_comb begin
        logic [31:0] st;
        st = 32'h00000000;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb0_d = wstrb0_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        isolate_d = isolate_q;
        clk_dir_d = clk_dir_q;
        strength_d = strength_q;
        turbo_d = turbo_q;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_have_d = 1'b1;
            awaddr_d = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_have_d = 1'b1;
            wdata_d = S_AXI_WDATA;
            wstrb0_d = S_AXI_WSTRB[0];
        end
        if (aw_have_q && w_have_q) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = pmrcp_pkg::AXI_OKAY;
            if (addr_hit(awaddr_q, pmrcp_pkg::BASIC_CTRL_OFFSET)) begin
                if (wstrb0_q) begin
                    isolate_d = wdata_q[pmrcp_pkg::ISOLATE_BIT];
                end
            end else if (addr_hit(awaddr_q, pmrcp_pkg::SPECIAL_CTRL_OFFSET)) begin
                if (wstrb0_q) begin
                    clk_dir_d = wdata_q[pmrcp_pkg::CLK_DIR_BIT];
                    strength_d = wdata_q[pmrcp_pkg::CLK_STRENGTH_BIT];
                    turbo_d = wdata_q[pmrcp_pkg::TURBO_200_BIT];
                end
            end else if (!addr_hit(awaddr_q, pmrcp_pkg::STATUS_OFFSET)) begin
                bresp_d = pmrcp_pkg::AXI_DECERR;
            end
        end
        if (bvalid_q && S_AXI_BREADY) begin
            bvalid_d = 1'b0;
        end
        st[pmrcp_pkg::ST_MODE_LSB +: 2] = mode;
        st[pmrcp_pkg::ST_OUTPUT_BIT] = (mode == pmrcp_pkg::PMRCP_MII_PHY) ||
            ((mode[1] == 1'b1) && clk_dir_q);
        st[pmrcp_pkg::ST_PULLDOWN_BIT] = pd_q;
        st[pmrcp_pkg::ST_INBUF_BIT] = inbuf_q;
        st[pmrcp_pkg::ST_DRIVE16_BIT] = drv16_q;
        st[pmrcp_pkg::ST_DRIVER_ON_BIT] = !oe_n_q;
        st[pmrcp_pkg::ST_CLK_TOGGLE_BIT] = tog_sync;
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_d = 1'b1;
            rresp_d = pmrcp_pkg::AXI_OKAY;
            rdata_d = 32'h00000000;
            if (addr_hit(S_AXI_ARADDR, pmrcp_pkg::BASIC_CTRL_OFFSET)) begin
                rdata_d[pmrcp_pkg::ISOLATE_BIT] = isolate_q;
            end else if (addr_hit(S_AXI_ARADDR, pmrcp_pkg::SPECIAL_CTRL_OFFSET)) begin
                rdata_d[pmrcp_pkg::CLK_DIR_BIT] = clk_dir_q;
                rdata_d[pmrcp_pkg::CLK_STRENGTH_BIT] = strength_q;
                rdata_d[pmrcp_pkg::TURBO_200_BIT] = turbo_q;
            end else if (addr_hit(S_AXI_ARADDR, pmrcp_pkg::STATUS_OFFSET)) begin
                rdata_d = st;
            end else begin
                rresp_d = pmrcp_pkg::AXI_DECERR;
            end
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_d = 1'b0;
        end
        if (!RESET_N) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            awaddr_d = 32'h00000000;
            wdata_d = 32'h00000000;
            wstrb0_d = 1'b0;
            bvalid_d = 1'b0;
            bresp_d = pmrcp_pkg::AXI_OKAY;
            rvalid_d = 1'b0;
            rresp_d = pmrcp_pkg::AXI_OKAY;
            rdata_d = 32'h00000000;
            isolate_d = pmrcp_pkg::ISOLATE_RESET;
            clk_dir_d = pmrcp_pkg::CLK_DIR_RESET;
            strength_d = pmrcp_pkg::CLK_STRENGTH_RESET;
            turbo_d = pmrcp_pkg::TURBO_200_RESET;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        aw_have_q <= aw_have_d;
        w_have_q <= w_have_d;
        awaddr_q <= awaddr_d;
        wdata_q <= wdata_d;
        wstrb0_q <= wstrb0_d;
        bvalid_q <= bvalid_d;
        bresp_q <= bresp_d;
        rvalid_q <= rvalid_d;
        rresp_q <= rresp_d;
        rdata_q <= rdata_d;
        isolate_q <= isolate_d;
        clk_dir_q <= clk_dir_d;
        strength_q <= strength_d;
        turbo_q <= turbo_d;
    end

    // Pad controls are recomputed every cycle from the latched mode and control bits.
    always_comb begin
        oe_n_d = 1'b1;
        pd_d = 1'b1;
        inbuf_d = 1'b1;
        drv16_d = 1'b0;
        case (mode)
            pmrcp_pkg::PMRCP_MII_MAC: begin
                oe_n_d = 1'b1;
            end
            pmrcp_pkg::PMRCP_MII_PHY: begin
                oe_n_d = isolate_q;
                pd_d = 1'b0;
                inbuf_d = 1'b0;
                drv16_d = turbo_q && strength_q;
            end
            pmrcp_pkg::PMRCP_RMII_MAC, pmrcp_pkg::PMRCP_RMII_PHY: begin
                if (clk_dir_q) begin
                    oe_n_d = (mode == pmrcp_pkg::PMRCP_RMII_PHY) && isolate_q;
                    pd_d = 1'b0;
                    inbuf_d = 1'b0;
                    drv16_d = strength_q;
                end else begin
                    oe_n_d = 1'b1;
                    pd_d = !((mode == pmrcp_pkg::PMRCP_RMII_PHY) && isolate_q);
                    inbuf_d = !((mode == pmrcp_pkg::PMRCP_RMII_PHY) && isolate_q);
                end
            end
            default: begin
                oe_n_d = 1'b1;
            end
        endcase
        if (!RESET_N) begin
            oe_n_d = 1'b1;
            pd_d = 1'b1;
            inbuf_d = 1'b1;
            drv16_d = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        oe_n_q <= oe_n_d;
        pd_q <= pd_d;
        inbuf_q <= inbuf_d;
        drv16_q <= drv16_d;
    end

    // The driven clock is the internal 50 MHz reference, forwarded to the pin output at all times; OE_N alone turns the driver on.
    assign PORT0_TRANSMIT_SIDE_CLOCK_PIN_O = INT_REF_CLK_50M;
    assign PORT0_TRANSMIT_SIDE_CLOCK_PIN_OE_N = oe_n_q;
    assign PORT0_TRANSMIT_SIDE_CLOCK_PIN_PULLDOWN_EN = pd_q;
    assign PORT0_TRANSMIT_SIDE_CLOCK_PIN_INBUF_EN = inbuf_q;
    assign PORT0_TRANSMIT_SIDE_CLOCK_PIN_DRIVE_16MA = drv16_q;
    assign PORT0_MODE = mode;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    sequence rmii_out_s;
        mode[1] && clk_dir_q;
    endsequence

    sequence rmii_phy_iso_s;
        (mode == pmrcp_pkg::PMRCP_RMII_PHY) && isolate_q;
    endsequence

    mii_mac_input_a: assert property ((mode == pmrcp_pkg::PMRCP_MII_MAC) |=> oe_n_q && pd_q && inbuf_q)
        else $error("MII MAC clock pin not an input");

    mii_phy_drive_a: assert property ((mode == pmrcp_pkg::PMRCP_MII_PHY) && !isolate_q |=> !oe_n_q && !inbuf_q)
        else $error("MII PHY clock pin not driven");

    phy_isolate_off_a: assert property ((mode == pmrcp_pkg::PMRCP_MII_PHY) && isolate_q |=> oe_n_q)
        else $error("MII PHY driver on while isolated");

    turbo_strength_a: assert property ((mode == pmrcp_pkg::PMRCP_MII_PHY) |=> drv16_q == $past(turbo_q && strength_q))
        else $error("MII PHY drive select wrong");

    rmii_dir_a: assert property (mode == pmrcp_pkg::PMRCP_RMII_MAC |=> oe_n_q == !$past(clk_dir_q))
        else $error("RMII MAC direction does not follow control");

    rmii_out_pads_a: assert property (rmii_out_s |=> !pd_q && !inbuf_q && drv16_q == $past(strength_q))
        else $error("RMII output pad settings wrong");

    rmii_phy_in_iso_a: assert property (rmii_phy_iso_s ##0 !clk_dir_q |=> !pd_q && !inbuf_q && oe_n_q)
        else $error("RMII PHY input not isolated");

    rmii_phy_out_iso_a: assert property (rmii_phy_iso_s ##0 rmii_out_s |=> oe_n_q)
        else $error("RMII PHY driver on while isolated");

    rmii_mac_pd_a: assert property (mode == pmrcp_pkg::PMRCP_RMII_MAC && !clk_dir_q |=> pd_q && inbuf_q)
        else $error("RMII MAC input pull-down off");

    iso_write_pad_a: assert property ((mode == pmrcp_pkg::PMRCP_MII_PHY) && aw_have_q && w_have_q && wstrb0_q &&
        addr_hit(awaddr_q, pmrcp_pkg::BASIC_CTRL_OFFSET) |=> ##1 oe_n_q == $past(wdata_q[pmrcp_pkg::ISOLATE_BIT], 2))
        else $error("isolate write did not reach the pad in two cycles");
endmodule

/* sim/pmrcp_far_end.sv */
// Behavioural far-side device that supplies the pin clock while the pin is an input.
`timescale 1ns/1ns
module pmrcp_far_end (
    input wire logic run,
    input wire logic pin_is_input,
    output logic clk_out,
    output logic driving
);
    // The far side drives its clock only while the device leaves the pin as an input.
    assign driving = run && (pin_is_input === 1'b1);

    initial begin
        clk_out = 1'b0;
        #7;
        forever #80 clk_out = driving ? ~clk_out : 1'b0;
    end
endmodule

/* sim/port0_mii_rmii_clock_pin_control_test.sv */
// Self-checking testbench for the port 0 clock pin control block.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin error_cnt++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module port0_mii_rmii_clock_pin_control_test;
    localparam logic [31:0] A_BASIC = {28'h0, pmrcp_pkg::BASIC_CTRL_OFFSET};
    localparam logic [31:0] A_SPEC = {28'h0, pmrcp_pkg::SPECIAL_CTRL_OFFSET};
    localparam logic [31:0] A_STAT = {28'h0, pmrcp_pkg::STATUS_OFFSET};
    logic clk, rst_n, ref_clk, s0, s1, run, pin_o, oe_n, pd, ib, d16, far_clk, far_drv, pin_wire, pin_clk;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, mode, r;
    logic [15:0] lfsr;
    int error_cnt, n_tests, m, c, n;

    // Pin level from whoever drives it; the pull-down holds it low otherwise.
    assign pin_wire = (oe_n === 1'b0) ? pin_o : (far_drv ? far_clk : 1'b0);
    assign pin_clk = ib ? pin_wire : 1'b0;

    pmrcp_far_end u_pmrcp_far_end (.run(run), .pin_is_input(oe_n), .clk_out(far_clk), .driving(far_drv));

    pmrcp_top u_pmrcp_top (
        .SYS_CLK(clk), .RESET_N(rst_n), .PORT0_TRANSMIT_SIDE_CLOCK_PIN_CLK(pin_clk), .INT_REF_CLK_50M(ref_clk),
        .PORT0_MODE_STRAP_BIT0(s0), .PORT0_MODE_STRAP_BIT1(s1), .PORT0_TRANSMIT_SIDE_CLOCK_PIN_O(pin_o),
        .PORT0_TRANSMIT_SIDE_CLOCK_PIN_OE_N(oe_n), .PORT0_TRANSMIT_SIDE_CLOCK_PIN_PULLDOWN_EN(pd),
        .PORT0_TRANSMIT_SIDE_CLOCK_PIN_INBUF_EN(ib), .PORT0_TRANSMIT_SIDE_CLOCK_PIN_DRIVE_16MA(d16),
        .PORT0_MODE(mode), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        ref_clk = 1'b0;
        #3;
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Expected pad controls as {oe_n, pull-down, input buffer, drive 16 mA}.
    function automatic logic [3:0] exp_pads(input logic [1:0] md, input logic iso, dir, str, tur);
        if (md == 2'b00) return 4'b1110;
        if (md == 2'b01) return {iso, 2'b00, tur & str};
        if (dir) return {md[0] & iso, 2'b00, str};
        return {1'b1, !(md[0] & iso), !(md[0] & iso), 1'b0};
    endfunction

    task automatic test_done;
        $display("Checks made %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic time_out(input string nm);
        error_cnt++;
        $display("[FAIL] %s expected handshake seen timeout", nm);
        test_done();
    endtask

    task automatic axi_wr(input logic [31:0] a, d, input logic [3:0] s, output logic [1:0] rs);
        logic ta, tw, done;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 100 && !done; i++) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid && bready;
            rs = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
        if (!done) time_out("write");
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
        logic ta, done;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 100 && !done; i++) begin
            @(negedge clk);
            ta = arvalid && arready;
            done = rvalid && rready;
            d = rdata;
            rs = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        if (!done) time_out("read");
    endtask

    task automatic do_reset(input logic [1:0] md);
        @(posedge clk);
        s0 <= md[0];
        s1 <= md[1];
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task automatic chk_pads(input logic [1:0] md, input logic iso, dir, str, tur);
        logic [3:0] e;
        logic [6:0] st;
        e = exp_pads(md, iso, dir, str, tur);
        st = {~e[3], e[0], e[1], e[2], (md == 2'b01) | (md[1] & dir), md};
        @(negedge clk);
        `CHK("oe_n", e[3], oe_n)
        `CHK("pulldown", e[2], pd)
        `CHK("inbuf", e[1], ib)
        `CHK("drive16", e[0], d16)
        `CHK("pin_o", ref_clk, pin_o)
        axi_rd(A_STAT, rd, r);
        `CHK("rresp", pmrcp_pkg::AXI_OKAY, r)
        `CHK("status", st, rd[6:0])
        `CHK("status_high", 24'h0, rd[31:8])
    endtask

    task automatic count_toggles(output int cnt);
        logic last;
        cnt = 0;
        axi_rd(A_STAT, rd, r);
        last = rd[pmrcp_pkg::ST_CLK_TOGGLE_BIT];
        repeat (10) begin
            axi_rd(A_STAT, rd, r);
            if (rd[pmrcp_pkg::ST_CLK_TOGGLE_BIT] !== last) cnt++;
            last = rd[pmrcp_pkg::ST_CLK_TOGGLE_BIT];
        end
    endtask

    initial begin
        {rst_n, s0, s1, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr, wstrb} = '0;
        run = 1'b1;
        error_cnt = 0;
        n_tests = 0;
        lfsr = 16'hf2ff;
        for (m = 0; m < 4; m++) begin
            do_reset(m[1:0]);
            `CHK("mode", m[1:0], mode)
            axi_rd(A_BASIC, rd, r);
            `CHK("basic_reset", 32'h0, rd)
            axi_rd(A_SPEC, rd, r);
            `CHK("special_reset", 32'h0, rd)
            chk_pads(m[1:0], 1'b0, 1'b0, 1'b0, 1'b0);
            for (c = 0; c < 16; c++) begin
                lfsr = lfsr_next(lfsr);
                axi_wr(A_BASIC, {lfsr, 15'h0, c[0]}, 4'hf, r);
                `CHK("bresp", pmrcp_pkg::AXI_OKAY, r)
                axi_wr(A_SPEC, {lfsr_next(lfsr), 13'h0, c[3:1]}, 4'hf, r);
                repeat (3) @(posedge clk);
                chk_pads(m[1:0], c[0], c[1], c[2], c[3]);
            end
        end
        axi_rd(A_SPEC, rd, r);
        `CHK("special_readback", 32'h7, rd)
        @(posedge clk);
        s0 <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK("mode_held", 2'b11, mode)
        axi_wr(A_SPEC, 32'h0, 4'hf, r);
        repeat (8) @(posedge clk);
        count_toggles(n);
        `CHK("iso_clock_blocked", 0, n)
        axi_wr(A_BASIC, 32'h0, 4'hf, r);
        repeat (8) @(posedge clk);
        count_toggles(n);
        `CHK("input_clock_seen", 1'b1, n > 0)
        axi_wr(32'hc, 32'h1, 4'hf, r);
        `CHK("unmapped_wr", pmrcp_pkg::AXI_DECERR, r)
        axi_rd(32'hc, rd, r);
        `CHK("unmapped_rd", pmrcp_pkg::AXI_DECERR, r)
        `CHK("unmapped_data", 32'h0, rd)
        axi_wr(32'h10, 32'h1, 4'hf, r);
        `CHK("alias_wr", pmrcp_pkg::AXI_DECERR, r)
        axi_wr(A_STAT, 32'hff, 4'hf, r);
        `CHK("status_wr", pmrcp_pkg::AXI_OKAY, r)
        axi_wr(A_SPEC, 32'h7, 4'h0, r);
        axi_rd(A_SPEC, rd, r);
        `CHK("strobe_off", 32'h0, rd)
        chk_pads(2'b11, 1'b0, 1'b0, 1'b0, 1'b0);
        test_done();
    end
endmodule
